// [shared/cam_port_pkg.sv]
// Constants, offsets and reset values of the second camera input port.
// Assumes byte registers on a 16-bit byte address and a 20 MHz system clock.
package cam_port_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_PORT_CTL = 16'h0D40;
  localparam logic [15:0] OFS_CLK_CTL = 16'h0D42;
  localparam logic [15:0] OFS_POLARITY = 16'h0D44;
  localparam logic [15:0] OFS_CFG0 = 16'h0D46;
  localparam logic [15:0] OFS_CFG1 = 16'h0D47;
  localparam logic [15:0] OFS_CAP_CTL = 16'h0D48;
  localparam logic [15:0] OFS_FLAG_CLR = 16'h0D49;
  localparam logic [15:0] OFS_HSIZE_LO = 16'h0D4A;
  localparam logic [15:0] OFS_HSIZE_HI = 16'h0D4B;
  localparam logic [15:0] OFS_VSIZE_LO = 16'h0D4C;
  localparam logic [15:0] OFS_VSIZE_HI = 16'h0D4D;
  localparam logic [15:0] OFS_STATUS = 16'h0D4E;
  localparam logic [15:0] OFS_SYNC_TIM = 16'h0D72;
  localparam logic [15:0] OFS_RANGE_END = 16'h0D75;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PORT_CTL = 8'h00;
  localparam logic [7:0] RST_CLK_CTL = 8'h00;
  localparam logic [7:0] RST_POLARITY = 8'h00;
  localparam logic [7:0] RST_CFG0 = 8'h04;
  localparam logic [7:0] RST_CFG1 = 8'h00;
  localparam logic [7:0] RST_CAP_CTL = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_SW_RESET = 7;
  localparam int BIT_PORT_EN = 0;
  localparam int BIT_CLK_OFF = 7;
  localparam int DIV_LSB = 2;
  localparam int DIV_W = 5;
  localparam int BIT_PCLK_POL = 0;
  localparam int BIT_DV_POL = 0;
  localparam int BIT_HS_POL = 1;
  localparam int BIT_VS_POL = 2;
  localparam int BIT_EMBEDDED = 7;
  localparam int BIT_UV_OFFSET = 5;
  localparam int ORDER_LSB = 3;
  localparam int FMT_LSB = 1;
  localparam int BIT_USE_DV = 0;
  localparam int BIT_CAP_RUN = 6;
  localparam int BIT_EVT_END = 5;
  localparam int SAMPLE_LSB = 0;
  localparam int SAMPLE_W = 3;
  localparam int BIT_EVT_CLR = 0;
  localparam int ST_EVENT = 5;
  localparam int ST_CAPTURING = 4;
  localparam int ST_VALID = 3;
  localparam int ST_RAW_VS = 2;
  localparam int SIZE_HI_W = 3;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] FMT_YUV8 = 2'b00;
  localparam logic [1:0] FMT_RGB24 = 2'b10;
  localparam logic [1:0] ROLE_Y = 2'b00;
  localparam logic [1:0] ROLE_U = 2'b01;
  localparam logic [1:0] ROLE_V = 2'b10;
  localparam logic [23:0] EMB_PREAMBLE = 24'hFF0000;
  localparam int EMB_H_BIT = 4;
  localparam int EMB_V_BIT = 5;

  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_ARMED = 2'b01,
    CAP_ACTIVE = 2'b11,
    CAP_SKIP = 2'b10
  } cap_state_t;

endpackage

// [shared/cam_div_if.sv]
// Link between the port control logic and its camera clock divider.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface cam_div_if;
  logic [cam_port_pkg::DIV_W-1:0] div_sel;
  logic run;
  logic clk_out;
  modport ctrl (output div_sel, output run, input clk_out);
  modport div (input div_sel, input run, output clk_out);
endinterface

// [hdl/cam_clock_divider.sv]
// Camera clock output divider.
// Assumes one system clock; the output is a registered level.
`timescale 1ns/1ps
module cam_clock_divider (
  input wire logic clk,
  input wire logic rst_n,
  cam_div_if.div link
);

  typedef struct packed {
    logic [cam_port_pkg::DIV_W-1:0] cnt;
    logic out;
  } div_state_t;

  div_state_t div_reg;
  div_state_t div_next;

  // ----------------------------------------------------------------
  // Period is 2*(select+1) system clocks
  // ----------------------------------------------------------------
  always_comb begin
    div_next = div_reg;
    if (!link.run) begin
      div_next = '0;
    end else if (div_reg.cnt >= link.div_sel) begin
      div_next.cnt = '0;
      div_next.out = ~div_reg.out;
    end else begin
      div_next.cnt = div_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign link.clk_out = div_reg.out;

endmodule // cam_clock_divider

// [hdl/camera_input_port_control.sv]
// Control, configuration, status and pixel capture of camera input port 2.
// Assumes camera pins are synchronous to clk, which runs far above the
// pixel clock, and a byte register port with read data one cycle later.
//
// Notes on behaviour
// - Writing one to soft reset bit restores every port register to default.
// - Clock register bit 7 set stops the camera clock output.
// - Camera clock divides system clock by a five-bit select in bits 6-2.
// - Data-valid polarity comes from polarity register bit 0.
// - Config 0 bit 7 selects embedded sync codes instead of sync pins.
// - Sync timing registers have no effect while embedded sync is on.
// - Config 0 bit 5 treats chroma as offset binary instead of straight.
// - Config 0 bits 4-3 choose byte order UYVY, VYUY, YUYV or YVYU.
// - Config 0 bits 2-1 choose YUV 4:2:2 or RGB 8:8:8; reset 04h.
// - Config 1 bit 0 makes data-valid qualify captured pixels.
// - Capture bit 6 starts capture; clearing stops after current frame.
// - Status bit 5 flags a frame event since the last clear.
// - Writing one to flag clear bit 0 clears the event flag.
// - Capture bits 2-0 set how many frames are skipped between captures.
// - Status bit 4 shows a frame in progress, valid or skipped.
// - Status bit 3 shows the latest frame since capture start is or was captured, not skipped.
// - Status bit 2 shows vsync pin, inverted when its polarity bit set.
`timescale 1ns/1ps
module camera_input_port_control (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic cam_pixel_clock_in,
  input wire logic cam_vsync_in,
  input wire logic cam_hsync_in,
  input wire logic cam_data_valid_in,
  input wire logic [23:0] cam_data_in,
  output logic cam_clock_out,
  output logic [31:0] pixel_data,
  output logic pixel_valid,
  output logic [10:0] input_hsize,
  output logic [10:0] input_vsize,
  output logic [31:0] sync_timing
);

  typedef struct packed {
    logic [7:0] port_ctl;
    logic [7:0] clk_ctl;
    logic [7:0] pol;
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    logic [7:0] cap_ctl;
    logic [10:0] hsize;
    logic [10:0] vsize;
    logic [31:0] stim;
    logic [31:0] stim_eff;
    logic [7:0] rdata;
    cam_port_pkg::cap_state_t st;
    logic [2:0] skip;
    logic evt;
    logic valid_seen;
    logic pclk_d;
    logic vact_d;
    logic emb_vact;
    logic emb_line;
    logic [23:0] hist;
    logic [1:0] bidx;
    logic [7:0] u;
    logic [7:0] v;
    logic [7:0] y0;
    logic [7:0] y1;
    logic [31:0] pix;
    logic pix_v;
  } state_t;

  localparam state_t RESET_STATE = '{
    port_ctl: cam_port_pkg::RST_PORT_CTL,
    clk_ctl: cam_port_pkg::RST_CLK_CTL,
    pol: cam_port_pkg::RST_POLARITY,
    cfg0: cam_port_pkg::RST_CFG0,
    cfg1: cam_port_pkg::RST_CFG1,
    cap_ctl: cam_port_pkg::RST_CAP_CTL,
    st: cam_port_pkg::CAP_IDLE,
    default: '0
  };

  state_t s_reg;
  state_t s_next;

  // ----------------------------------------------------------------
  // Byte role within a four-byte 4:2:2 group
  // ----------------------------------------------------------------
  function automatic logic [1:0] byte_role(input logic [1:0] order, input logic [1:0] idx);
    logic [1:0] r;
    r = cam_port_pkg::ROLE_Y;
    case (order)
      2'b00: r = idx == 2'd0 ? cam_port_pkg::ROLE_U
               : idx == 2'd2 ? cam_port_pkg::ROLE_V : cam_port_pkg::ROLE_Y;
      2'b01: r = idx == 2'd0 ? cam_port_pkg::ROLE_V
               : idx == 2'd2 ? cam_port_pkg::ROLE_U : cam_port_pkg::ROLE_Y;
      2'b10: r = idx == 2'd1 ? cam_port_pkg::ROLE_U
               : idx == 2'd3 ? cam_port_pkg::ROLE_V : cam_port_pkg::ROLE_Y;
      2'b11: r = idx == 2'd1 ? cam_port_pkg::ROLE_V
               : idx == 2'd3 ? cam_port_pkg::ROLE_U : cam_port_pkg::ROLE_Y;
      default: r = cam_port_pkg::ROLE_Y;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Camera clock divider
  // ----------------------------------------------------------------
  cam_div_if div_link ();

  assign div_link.div_sel = s_reg.clk_ctl[cam_port_pkg::DIV_LSB +: cam_port_pkg::DIV_W];
  assign div_link.run = s_reg.port_ctl[cam_port_pkg::BIT_PORT_EN]
                        & ~s_reg.clk_ctl[cam_port_pkg::BIT_CLK_OFF];

  cam_clock_divider u_div (
    .clk(clk),
    .rst_n(rst_n),
    .link(div_link)
  );

  // ----------------------------------------------------------------
  // Decoded pin levels
  // ----------------------------------------------------------------
  logic enabled;
  logic embedded;
  logic pix_edge;
  logic vs_act;
  logic hs_act;
  logic dv_ok;
  logic vact_now;
  logic line_ok;
  logic frame_start;
  logic frame_end;
  logic frame_evt;
  logic [7:0] status;
  logic [7:0] byte_in;
  logic [1:0] role;

  assign enabled = s_reg.port_ctl[cam_port_pkg::BIT_PORT_EN];
  assign embedded = s_reg.cfg0[cam_port_pkg::BIT_EMBEDDED];
  assign byte_in = cam_data_in[7:0];
  assign pix_edge = s_reg.clk_ctl[cam_port_pkg::BIT_PCLK_POL]
                    ? (s_reg.pclk_d & ~cam_pixel_clock_in)
                    : (~s_reg.pclk_d & cam_pixel_clock_in);
  assign vs_act = cam_vsync_in ^ s_reg.pol[cam_port_pkg::BIT_VS_POL];
  assign hs_act = cam_hsync_in ^ s_reg.pol[cam_port_pkg::BIT_HS_POL];
  assign dv_ok = ~s_reg.cfg1[cam_port_pkg::BIT_USE_DV]
                 | (cam_data_valid_in ^ s_reg.pol[cam_port_pkg::BIT_DV_POL]);
  // Embedded mode ignores the sync pins for frame and line timing; status bit 2 still shows vsync
  assign vact_now = embedded ? s_reg.emb_vact : vs_act;
  assign line_ok = embedded ? s_reg.emb_line : hs_act;
  assign frame_start = enabled & pix_edge & vact_now & ~s_reg.vact_d;
  assign frame_end = enabled & pix_edge & ~vact_now & s_reg.vact_d;
  assign frame_evt = s_reg.cap_ctl[cam_port_pkg::BIT_EVT_END] ? frame_end : frame_start;
  assign role = byte_role(s_reg.cfg0[cam_port_pkg::ORDER_LSB +: 2], s_reg.bidx);

  always_comb begin
    status = 8'h00;
    status[cam_port_pkg::ST_EVENT] = s_reg.evt;
    status[cam_port_pkg::ST_CAPTURING] = (s_reg.st == cam_port_pkg::CAP_ACTIVE)
                                         | (s_reg.st == cam_port_pkg::CAP_SKIP);
    status[cam_port_pkg::ST_VALID] = s_reg.valid_seen;
    status[cam_port_pkg::ST_RAW_VS] = cam_vsync_in ^ s_reg.pol[cam_port_pkg::BIT_VS_POL];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] b;
    logic clr;
    b = byte_in;
    clr = 1'b0;
    s_next = s_reg;
    s_next.pix_v = 1'b0;

    // Register reads: data stands only in the cycle after the strobe
    s_next.rdata = 8'h00;
    if (reg_read) begin
      case (reg_addr)
        cam_port_pkg::OFS_PORT_CTL: s_next.rdata = {1'b0, s_reg.port_ctl[6:0]};
        cam_port_pkg::OFS_CLK_CTL: s_next.rdata = s_reg.clk_ctl;
        cam_port_pkg::OFS_POLARITY: s_next.rdata = s_reg.pol;
        cam_port_pkg::OFS_CFG0: s_next.rdata = s_reg.cfg0;
        cam_port_pkg::OFS_CFG1: s_next.rdata = s_reg.cfg1;
        cam_port_pkg::OFS_CAP_CTL: s_next.rdata = s_reg.cap_ctl;
        cam_port_pkg::OFS_HSIZE_LO: s_next.rdata = s_reg.hsize[7:0];
        cam_port_pkg::OFS_HSIZE_HI: s_next.rdata = {5'h00, s_reg.hsize[10:8]};
        cam_port_pkg::OFS_VSIZE_LO: s_next.rdata = s_reg.vsize[7:0];
        cam_port_pkg::OFS_VSIZE_HI: s_next.rdata = {5'h00, s_reg.vsize[10:8]};
        cam_port_pkg::OFS_STATUS: s_next.rdata = status;
        cam_port_pkg::OFS_SYNC_TIM: s_next.rdata = s_reg.stim[7:0];
        cam_port_pkg::OFS_SYNC_TIM + 16'h0001: s_next.rdata = s_reg.stim[15:8];
        cam_port_pkg::OFS_SYNC_TIM + 16'h0002: s_next.rdata = s_reg.stim[23:16];
        cam_port_pkg::OFS_RANGE_END: s_next.rdata = s_reg.stim[31:24];
        default: s_next.rdata = 8'h00;
      endcase
    end

    // Register writes
    if (reg_write) begin
      case (reg_addr)
        cam_port_pkg::OFS_PORT_CTL: s_next.port_ctl = {1'b0, reg_wdata[6:0]};
        cam_port_pkg::OFS_CLK_CTL: s_next.clk_ctl = reg_wdata;
        cam_port_pkg::OFS_POLARITY: s_next.pol = reg_wdata;
        cam_port_pkg::OFS_CFG0: s_next.cfg0 = reg_wdata;
        cam_port_pkg::OFS_CFG1: s_next.cfg1 = reg_wdata;
        cam_port_pkg::OFS_CAP_CTL: s_next.cap_ctl = reg_wdata;
        cam_port_pkg::OFS_FLAG_CLR: clr = reg_wdata[cam_port_pkg::BIT_EVT_CLR];
        cam_port_pkg::OFS_HSIZE_LO: s_next.hsize[7:0] = reg_wdata;
        cam_port_pkg::OFS_HSIZE_HI: s_next.hsize[10:8] = reg_wdata[2:0];
        cam_port_pkg::OFS_VSIZE_LO: s_next.vsize[7:0] = reg_wdata;
        cam_port_pkg::OFS_VSIZE_HI: s_next.vsize[10:8] = reg_wdata[2:0];
        cam_port_pkg::OFS_SYNC_TIM: s_next.stim[7:0] = reg_wdata;
        cam_port_pkg::OFS_SYNC_TIM + 16'h0001: s_next.stim[15:8] = reg_wdata;
        cam_port_pkg::OFS_SYNC_TIM + 16'h0002: s_next.stim[23:16] = reg_wdata;
        cam_port_pkg::OFS_RANGE_END: s_next.stim[31:24] = reg_wdata;
        default: s_next.rdata = s_next.rdata;
      endcase
    end

    // Frame event flag: a new event beats a clear in the same cycle
    s_next.evt = (enabled & frame_evt) | (s_reg.evt & ~clr);

    // Embedded sync decode on each pixel edge
    s_next.pclk_d = cam_pixel_clock_in;
    if (pix_edge) begin
      s_next.hist = {s_reg.hist[15:0], b};
      s_next.vact_d = vact_now;
    end
    if (enabled & pix_edge & embedded & s_reg.hist == cam_port_pkg::EMB_PREAMBLE) begin
      s_next.emb_vact = ~b[cam_port_pkg::EMB_V_BIT];
      s_next.emb_line = ~b[cam_port_pkg::EMB_H_BIT] & ~b[cam_port_pkg::EMB_V_BIT];
      // The code byte after the preamble never joins a group; a partial group is dropped
      s_next.bidx = 2'd0;
    end

    // Capture sequencing
    case (s_reg.st)
      cam_port_pkg::CAP_IDLE: begin
        if (s_reg.cap_ctl[cam_port_pkg::BIT_CAP_RUN]) begin
          s_next.st = cam_port_pkg::CAP_ARMED;
          s_next.skip = 3'd0;
          s_next.valid_seen = 1'b0;
        end
      end
      cam_port_pkg::CAP_ARMED, cam_port_pkg::CAP_SKIP: begin
        if (s_reg.st == cam_port_pkg::CAP_ARMED
            && !s_reg.cap_ctl[cam_port_pkg::BIT_CAP_RUN]) begin
          s_next.st = cam_port_pkg::CAP_IDLE;
        end else if (s_reg.st == cam_port_pkg::CAP_SKIP && frame_end) begin
          s_next.st = s_reg.cap_ctl[cam_port_pkg::BIT_CAP_RUN]
                      ? cam_port_pkg::CAP_ARMED : cam_port_pkg::CAP_IDLE;
        end else if (s_reg.st == cam_port_pkg::CAP_ARMED && frame_start) begin
          s_next.bidx = 2'd0;
          if (s_reg.skip == 3'd0) begin
            s_next.st = cam_port_pkg::CAP_ACTIVE;
            s_next.skip = s_reg.cap_ctl[cam_port_pkg::SAMPLE_LSB +: cam_port_pkg::SAMPLE_W];
            s_next.valid_seen = 1'b1;
          end else begin
            s_next.st = cam_port_pkg::CAP_SKIP;
            s_next.skip = s_reg.skip - 3'd1;
            s_next.valid_seen = 1'b0;
          end
        end
      end
      cam_port_pkg::CAP_ACTIVE: begin
        if (frame_end) begin
          s_next.st = s_reg.cap_ctl[cam_port_pkg::BIT_CAP_RUN]
                      ? cam_port_pkg::CAP_ARMED : cam_port_pkg::CAP_IDLE;
        end
      end
      default: s_next.st = cam_port_pkg::CAP_IDLE;
    endcase

    // Pixel assembly
    if (s_reg.st == cam_port_pkg::CAP_ACTIVE && enabled && pix_edge && line_ok && dv_ok
        && !(embedded && s_reg.hist == cam_port_pkg::EMB_PREAMBLE)) begin
      if (s_reg.cfg0[cam_port_pkg::FMT_LSB +: 2] == cam_port_pkg::FMT_RGB24) begin
        s_next.pix = {8'h00, cam_data_in};
        s_next.pix_v = 1'b1;
      end else if (s_reg.cfg0[cam_port_pkg::FMT_LSB +: 2] == cam_port_pkg::FMT_YUV8) begin
        if (role != cam_port_pkg::ROLE_Y && s_reg.cfg0[cam_port_pkg::BIT_UV_OFFSET]) begin
          b[7] = ~b[7];
        end
        case (role)
          cam_port_pkg::ROLE_U: s_next.u = b;
          cam_port_pkg::ROLE_V: s_next.v = b;
          default: begin
            if (s_reg.bidx < 2'd2) begin
              s_next.y0 = b;
            end else begin
              s_next.y1 = b;
            end
          end
        endcase
        s_next.bidx = s_reg.bidx + 2'd1;
        if (s_reg.bidx == 2'd3) begin
          s_next.pix = {s_next.u, s_next.y0, s_next.v, s_next.y1};
          s_next.pix_v = 1'b1;
        end
      end
    end

    // Disabled port holds capture idle
    if (!enabled) begin
      s_next.st = cam_port_pkg::CAP_IDLE;
      s_next.bidx = 2'd0;
      s_next.emb_line = 1'b0;
    end

    s_next.stim_eff = s_next.cfg0[cam_port_pkg::BIT_EMBEDDED] ? 32'h0000_0000 : s_next.stim;

    if (reg_write && reg_addr == cam_port_pkg::OFS_PORT_CTL
        && reg_wdata[cam_port_pkg::BIT_SW_RESET]) begin
      s_next = RESET_STATE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= RESET_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s_reg.rdata;
  assign cam_clock_out = div_link.clk_out;
  assign pixel_data = s_reg.pix;
  assign pixel_valid = s_reg.pix_v;
  assign input_hsize = s_reg.hsize;
  assign input_vsize = s_reg.vsize;
  assign sync_timing = s_reg.stim_eff;

endmodule // camera_input_port_control

// [test/cam_source_model.sv]
// Behavioural camera source: pixel clock, sync levels and pixel data.
// Assumes the bench calls send_frame; the pixel clock stands still between frames.
`timescale 1ns/1ps
module cam_source_model (
  input wire logic clk,
  output logic pclk,
  output logic vsync,
  output logic hsync,
  output logic data_valid,
  output logic [23:0] data
);
  initial begin
    pclk = 1'b1;
    vsync = 1'b0;
    hsync = 1'b0;
    data_valid = 1'b0;
    data = 24'h5A5A5A;
  end

  // Four system clocks a pixel
  task automatic pix(input logic act, input logic [23:0] d);
    begin
      @(posedge clk);
      pclk <= 1'b0;
      hsync <= act;
      data_valid <= act;
      // Idle bus toggles so a stale pixel never looks valid
      data <= act ? d : ~data;
      repeat (2) @(posedge clk);
      pclk <= 1'b1;
      @(posedge clk);
    end
  endtask

  task automatic send_frame(input int n, input logic [23:0] base);
    begin
      @(posedge clk);
      vsync <= 1'b1;
      repeat (2) pix(1'b0, 24'h000000);
      for (int i = 0; i < n; i++)
        pix(1'b1, base + 24'(i));
      repeat (2) pix(1'b0, 24'h000000);
      @(posedge clk);
      vsync <= 1'b0;
      repeat (2) pix(1'b0, 24'h000000);
    end
  endtask
endmodule // cam_source_model

// [test/camera_input_port_control_properties.sv]
// Assertions on the camera port's register and pixel outputs.
// Assumes one clock domain and only the top module's ports.
`timescale 1ns/1ps
module camera_input_port_control_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic cam_vsync_in,
  input wire logic cam_clock_out,
  input wire logic pixel_valid,
  input wire logic [10:0] input_hsize,
  input wire logic [10:0] input_vsize,
  input wire logic [31:0] sync_timing
);
  // ----
  // Shadows: 3 enable, 2 clock off, 1 vsync polarity, 0 embedded
  // ----
  logic [3:0] shadow_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_reg <= 4'h0;
    end else if (reg_write && reg_addr == 16'h0D40 && reg_wdata[7]) begin
      shadow_reg <= 4'h0;
    end else if (reg_write) begin
      case (reg_addr)
        16'h0D40: shadow_reg[3] <= reg_wdata[0];
        16'h0D42: shadow_reg[2] <= reg_wdata[7];
        16'h0D44: shadow_reg[1] <= reg_wdata[2];
        16'h0D46: shadow_reg[0] <= reg_wdata[7];
        default: ;
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----
  // Properties
  // ----
  hsize_low_a: assert property (reg_write && reg_addr == 16'h0D4A |=>
    input_hsize[7:0] == $past(reg_wdata)) else $error("hsize low byte wrong");
  hsize_high_a: assert property (reg_write && reg_addr == 16'h0D4B |=>
    input_hsize[10:8] == $past(reg_wdata[2:0])) else $error("hsize high bits wrong");
  vsize_low_a: assert property (reg_write && reg_addr == 16'h0D4C |=>
    input_vsize[7:0] == $past(reg_wdata)) else $error("vsize low byte wrong");
  soft_reset_a: assert property (reg_write && reg_addr == 16'h0D40 && reg_wdata[7] |=>
    input_hsize == 11'h000 && input_vsize == 11'h000 && sync_timing == 32'h0 && !pixel_valid)
    else $error("soft reset left state");
  clock_gate_a: assert property ((!shadow_reg[3] || shadow_reg[2]) [*3] |->
    !cam_clock_out) else $error("clock out not stopped");
  port_off_a: assert property (!shadow_reg[3] [*3] |-> !pixel_valid)
    else $error("pixel while disabled");
  embedded_sync_a: assert property (shadow_reg[0] [*2] |-> sync_timing == 32'h0)
    else $error("sync timing not ignored");
  flag_read_a: assert property (reg_read && reg_addr == 16'h0D49 |=> reg_rdata == 8'h00)
    else $error("flag clear readable");
  raw_vsync_a: assert property (($stable(cam_vsync_in) && $stable(shadow_reg[1])) [*4] ##0
    (reg_read && reg_addr == 16'h0D4E) |=> reg_rdata[2] == ($past(cam_vsync_in) ^ shadow_reg[1]))
    else $error("raw vsync status wrong");

  cover property (pixel_valid);
  cover property ($rose(cam_clock_out));
  cover property (reg_read && reg_addr == 16'h0D4E ##1 reg_rdata[5]);
endmodule // camera_input_port_control_properties

bind camera_input_port_control camera_input_port_control_properties chk (
  .clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .cam_vsync_in, .cam_clock_out, .pixel_valid, .input_hsize, .input_vsize, .sync_timing
);

// [test/camera_input_port_control_tb.sv]
// Self-checking bench for the camera port control block.
// Assumes the source model and the bound checker.
`timescale 1ns/1ps
module camera_input_port_control_tb;
  logic clk, rst_n, reg_write, reg_read, pclk, vs, hs, dv, cam_clock_out, pixel_valid;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v, b;
  logic [23:0] cam_data, base;
  logic [31:0] pixel_data, sync_timing;
  logic [10:0] input_hsize, input_vsize, sz;
  int failures, checks_done, seed, p, n;
  logic [31:0] exp_q[$];
  logic [15:0] ra[9] = '{16'h0D42, 16'h0D44, 16'h0D46, 16'h0D47, 16'h0D48, 16'h0D49,
    16'h0D4B, 16'h0D4D, 16'h0D4F};

  camera_input_port_control DUT (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .cam_pixel_clock_in(pclk), .cam_vsync_in(vs), .cam_hsync_in(hs),
    .cam_data_valid_in(dv), .cam_data_in(cam_data), .cam_clock_out, .pixel_data,
    .pixel_valid, .input_hsize, .input_vsize, .sync_timing
  );
  cam_source_model src (.clk(clk), .pclk(pclk), .vsync(vs), .hsync(hs), .data_valid(dv),
    .data(cam_data));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----
  // Tasks and expectations
  // ----
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic push_rgb(input logic [23:0] bs);
    for (int i = 0; i < 4; i++)
      exp_q.push_back({8'h00, bs + 24'(i)});
  endtask
  task automatic fr(input logic [23:0] bs);
    src.send_frame(4, bs);
    repeat (4) @(posedge clk);
    chk("pending_words", 0, exp_q.size());
    exp_q.delete();
  endtask
  task automatic per(output int pr);
    int t0, r;
    logic prev;
    t0 = 0;
    r = 0;
    pr = 0;
    prev = 1'b1;
    for (int i = 0; i < 400 && r < 3; i++) begin
      @(posedge clk);
      #1;
      if (cam_clock_out === 1'b1 && prev === 1'b0) begin
        pr = i - t0;
        t0 = i;
        r++;
      end
      prev = cam_clock_out;
    end
  endtask
  function automatic logic [31:0] yuv(input logic [1:0] o, input logic off, input logic [7:0] c);
    logic [7:0] u, vv, y0, y1;
    logic [31:0] q;
    q = {c, c + 8'h01, c + 8'h02, c + 8'h03};
    case (o)
      2'h0: {u, y0, vv, y1} = q;
      2'h1: {vv, y0, u, y1} = q;
      2'h2: {y0, u, y1, vv} = q;
      default: {y0, vv, y1, u} = q;
    endcase
    return {u ^ {off, 7'h00}, y0, vv ^ {off, 7'h00}, y1};
  endfunction
  task automatic wrap_up();
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    if (pixel_valid === 1'b1) begin
      if (exp_q.size() == 0)
        chk("extra_word", 0, 1);
      else
        chk("pixel_data", exp_q.pop_front(), pixel_data);
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    wrap_up();
  end

  // ----
  // Scenarios
  // ----
  initial begin
    seed = 32'hB126;
    {reg_write, reg_read, reg_addr, reg_wdata} = '0;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("reset_value", ra[i] == 16'h0D46 ? 8'h04 : 8'h00, v);
    end
    sz = 11'($random(seed));
    wr(16'h0D4A, sz[7:0]);
    wr(16'h0D4B, {5'($random(seed)), sz[10:8]});
    chk("hsize", sz, input_hsize);
    wr(16'h0D4C, sz[10:3]);
    wr(16'h0D4D, 8'h07);
    chk("vsize", {3'h7, sz[10:3]}, input_vsize);
    wr(16'h0D46, 8'h00);
    wr(16'h0D40, 8'h80);
    rd(16'h0D46);
    chk("soft_reset_cfg0", 8'h04, v);
    chk("soft_reset_hsize", 0, input_hsize);
    wr(16'h0D40, 8'h01);
    for (int k = 0; k < 2; k++) begin
      b = k ? 8'($random(seed)) : 8'h00;
      wr(16'h0D42, {1'b0, b[4:0], 2'h0});
      per(p);
      chk("clk_period", 2 * (32'(b[4:0]) + 1), p);
    end
    wr(16'h0D42, 8'h80);
    n = 0;
    for (int k = 0; k < 84; k++) begin
      @(posedge clk);
      #1;
      if (k > 3 && cam_clock_out !== 1'b0)
        n++;
    end
    chk("clk_stopped", 0, n);
    for (int k = 1; k >= 0; k--) begin
      wr(16'h0D44, {5'h00, k[0], 2'h0});
      rd(16'h0D4E);
      chk("raw_vsync", k[0], v[2]);
    end
    wr(16'h0D48, 8'h40);
    base = 24'($random(seed));
    push_rgb(base);
    fr(base);
    rd(16'h0D4E);
    chk("status_after", 8'h28, v & 8'h3C);
    wr(16'h0D49, 8'h00);
    rd(16'h0D4E);
    chk("flag_kept", 1, v[5]);
    wr(16'h0D49, 8'h01);
    rd(16'h0D4E);
    chk("flag_cleared", 0, v[5]);
    wr(16'h0D48, 8'h41);
    for (int k = 0; k < 4; k++) begin
      base = 24'($random(seed));
      if (!k[0])
        push_rgb(base);
      fr(base);
    end
    wr(16'h0D48, 8'h40);
    push_rgb(24'h000100);
    fork
      fr(24'h000100);
      begin
        repeat (20) @(posedge clk);
        wr(16'h0D48, 8'h00);
      end
    join
    fr(24'h000010);
    for (int k = 0; k < 2; k++) begin
      wr(16'h0D49, 8'h01);
      wr(16'h0D48, {2'h0, k[0], 5'h00});
      fork
        fr(24'h000020);
        begin
          repeat (28) @(posedge clk);
          rd(16'h0D4E);
          chk("event_mid", !k[0], v[5]);
        end
      join
      rd(16'h0D4E);
      chk("event_after", 1, v[5]);
    end
    wr(16'h0D48, 8'h40);
    for (int k = 0; k < 4; k++) begin
      b = 8'($random(seed));
      n = $random(seed) & 1;
      wr(16'h0D46, {2'h0, n[0], k[1:0], 3'h0});
      exp_q.push_back(yuv(k[1:0], n[0], b));
      fr({16'h0000, b});
    end
    wr(16'h0D46, 8'h02);
    fr(24'h000030);
    wr(16'h0D46, 8'h84);
    wr(16'h0D72, 8'hA5);
    fr(24'h000040);
    wr(16'h0D46, 8'h04);
    wr(16'h0D47, 8'h01);
    wr(16'h0D44, 8'h01);
    fr(24'h000050);
    wr(16'h0D44, 8'h00);
    push_rgb(24'h000060);
    fr(24'h000060);
    wrap_up();
  end
endmodule // camera_input_port_control_tb
